// ### hw/cpd_pkg.sv
// constants, field positions and codes of the core datapath slice
// assumes one core clock and an active-low asynchronous reset
package cpd_pkg;
   localparam int unsigned NREG = 32;
   localparam int unsigned SPW = 11;
   localparam logic [5:0] IO_SP_LO = 6'h3D;
   localparam logic [5:0] IO_SP_HI = 6'h3E;
   localparam logic [5:0] IO_SW = 6'h3F;
   localparam logic [7:0] SP_LO_RST = 8'h00;
   localparam logic [7:0] SP_HI_RST = 8'h00;
   localparam logic [7:0] SW_RST = 8'h00;
   localparam int unsigned SW_I = 7;
   localparam int unsigned SW_T = 6;
   localparam int unsigned SW_H = 5;
   localparam int unsigned SW_S = 4;
   localparam int unsigned SW_V = 3;
   localparam int unsigned SW_N = 2;
   localparam int unsigned SW_Z = 1;
   localparam int unsigned SW_C = 0;
   localparam logic [3:0] PAIR_BASE = 4'hD;
   localparam int unsigned IRET_CYC = 4;
   localparam logic [1:0] IRET_LAST = 2'(IRET_CYC - 2);

   typedef enum logic [3:0] {
      ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
      ALU_AND = 4'h4, ALU_OR = 4'h5, ALU_EOR = 4'h6, ALU_COM = 4'h7,
      ALU_NEG = 4'h8, ALU_INC = 4'h9, ALU_DEC = 4'hA, ALU_LSR = 4'hB,
      ALU_ROR = 4'hC, ALU_ASR = 4'hD, ALU_SWAP = 4'hE, ALU_PASS = 4'hF
   } cpd_alu_op_t;

   typedef enum logic [3:0] {
      CMD_NOP = 4'h0, CMD_ALU = 4'h1, CMD_TSAVE = 4'h2, CMD_TLOAD = 4'h3,
      CMD_LOAD = 4'h4, CMD_STORE = 4'h5, CMD_PTR = 4'h6, CMD_PUSH = 4'h7,
      CMD_POP = 4'h8, CMD_CALL = 4'h9, CMD_RTN = 4'hA, CMD_IRQ = 4'hB,
      CMD_IRET = 4'hC, CMD_SEI = 4'hD, CMD_CLI = 4'hE, CMD_MOVW = 4'hF
   } cpd_cmd_t;

   typedef enum logic [1:0] {
      PTR_DISP = 2'h0, PTR_POSTINC = 2'h1, PTR_PREDEC = 2'h2
   } cpd_ptr_mode_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0, ST_IRET = 1'b1
   } cpd_state_t;
endpackage : cpd_pkg

// ### hw/cpd_alu_if.sv
// operand, result and flag bundle between core and arithmetic unit
// assumes cpd_pkg compiled first
interface cpd_alu_if;
   import cpd_pkg::*;
   logic [7:0] a;
   logic [7:0] b;
   logic cin;
   cpd_alu_op_t op;
   logic [7:0] res;
   logic [7:0] flags;
   logic [7:0] mask;
   modport alu (input a, b, cin, op, output res, flags, mask);
   modport core (output a, b, cin, op, input res, flags, mask);
endinterface : cpd_alu_if

// ### hw/cpd_alu.sv
// combinational 8-bit arithmetic, logic and bit unit with flags
// assumes the core registers result and flags on its own clock
module cpd_alu
   import cpd_pkg::*;
(
   // operands and results
   cpd_alu_if.alu bus
);
   always_comb
   begin
      logic [8:0] s;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] r;
      logic h;
      logic v;
      logic c;
      logic [7:0] m;
      s = 9'h000;
      a = bus.a;
      b = bus.b;
      r = 8'h00;
      h = 1'b0;
      v = 1'b0;
      c = 1'b0;
      m = 8'h1E;
      case (bus.op)
         ALU_ADD, ALU_ADC:
         begin
            s = {1'b0, a} + {1'b0, b} +
               {8'h00, bus.cin & (bus.op == ALU_ADC)};
            r = s[7:0];
            c = s[8];
            h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
            m = 8'h3F;
         end
         ALU_SUB, ALU_SBC:
         begin
            s = {1'b0, a} - {1'b0, b} -
               {8'h00, bus.cin & (bus.op == ALU_SBC)};
            r = s[7:0];
            c = s[8];
            h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
            m = 8'h3F;
         end
         ALU_AND: r = a & b;
         ALU_OR: r = a | b;
         ALU_EOR: r = a ^ b;
         ALU_COM:
         begin
            r = ~a;
            c = 1'b1;
            m = 8'h1F;
         end
         ALU_NEG:
         begin
            r = 8'h00 - a;
            c = |r;
            v = (r == 8'h80);
            h = r[3] | a[3];
            m = 8'h3F;
         end
         ALU_INC:
         begin
            r = a + 8'h01;
            v = (r == 8'h80);
         end
         ALU_DEC:
         begin
            r = a - 8'h01;
            v = (r == 8'h7F);
         end
         ALU_LSR, ALU_ROR, ALU_ASR:
         begin
            c = a[0];
            r = {a[7], a[7:1]};
            if (bus.op == ALU_LSR)
               r[7] = 1'b0;
            else if (bus.op == ALU_ROR)
               r[7] = bus.cin;
            v = r[7] ^ c;
            m = 8'h1F;
         end
         ALU_SWAP:
         begin
            r = {a[3:0], a[7:4]};
            m = 8'h00;
         end
         default:
         begin
            r = b;
            m = 8'h00;
         end
      endcase
      bus.res = r;
      bus.mask = m;
      bus.flags = {2'b00, h, r[7] ^ v, v, r[7], r == 8'h00, c}; // [RQ9]
   end
endmodule : cpd_alu

// ### hw/cpd_regfile.sv
// 32 x 8 working register file, two 8-bit reads, one pair read,
// one 8-bit write and one 16-bit pair write per clock
// assumes the caller never writes the same byte on both write ports
module cpd_regfile
   import cpd_pkg::*;
#(
   parameter int unsigned N = NREG
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // byte reads
   input wire logic [4:0] ra,
   input wire logic [4:0] rb,
   output logic [7:0] ra_d,
   output logic [7:0] rb_d,
   // pair read
   input wire logic [3:0] rp,
   output logic [15:0] rp_d,
   // byte write
   input wire logic we8,
   input wire logic [4:0] wa,
   input wire logic [7:0] wd8,
   // pair write
   input wire logic we16,
   input wire logic [3:0] wp,
   input wire logic [15:0] wd16
);
   logic [7:0] mem_r [N];
   logic [7:0] mem_nxt [N];

   if (N != NREG)
   begin : g_chk
      $error("register file must hold 32 entries");
   end

   for (genvar i = 0; i < N; i++)
   begin : g_ent
      always_comb
      begin
         mem_nxt[i] = mem_r[i];
         if (we8 && wa == 5'(i))
            mem_nxt[i] = wd8;
         if (we16 && {wp, i[0]} == 5'(i))
            mem_nxt[i] = i[0] ? wd16[15:8] : wd16[7:0]; // [RQ14]
      end
      always_ff @(posedge mclk or negedge arst_n)
      begin
         if (!arst_n)
            mem_r[i] <= 8'h00;
         else
            mem_r[i] <= mem_nxt[i];
      end
   end

   assign ra_d = mem_r[ra]; // [RQ14]
   assign rb_d = mem_r[rb];
   assign rp_d = {mem_r[{rp, 1'b1}], mem_r[{rp, 1'b0}]}; // [RQ16]
endmodule : cpd_regfile

// ### hw/cpd_core.sv
// core datapath slice: arithmetic unit, status word, register file,
// pointer pairs and stack pointer, driven by the decoder's commands
// assumes the decoder sequences memory and presents one command a clock
// Function
// RQ1 - one-cycle operation on two registers or register and immediate
// RQ2 - arithmetic, logic and bit groups on all 32 working registers
// RQ3 - status word updated after every arithmetic unit operation; swap and pass give a zero mask and leave it unchanged
// RQ4 - status word never saved or restored on interrupt entry or return
// RQ5 - bit 7 clear blocks every interrupt
// RQ6 - bit 7 cleared on interrupt, set by return, set/clear commands
// RQ7 - bit 6 holds a copied register bit for store and load
// RQ8 - bit 5 records carry out of the low nibble
// RQ9 - bit 4 equals negative xor overflow
// RQ10 - bit 3 records two's complement overflow
// RQ11 - bit 2 set on negative result
// RQ12 - bit 1 set on zero result
// RQ13 - bit 0 set on carry
// RQ14 - register file offers four read/write port widths
// RQ15 - registers also reachable at data addresses 0x00 to 0x1F
// RQ16 - top six registers pair into three pointers, low byte first
// RQ17 - pointers give displacement, post-increment and pre-decrement
// RQ18 - stack grows down; byte push minus one, pop plus one
// RQ19 - call and interrupt minus two, returns plus two
// RQ20 - stack pointer in two I/O registers, high keeps bits 10..8
// RQ21 - software loads stack pointer above 0xFF before calls
// RQ22 - core runs undivided from the chip clock
// RQ23 - next fetch overlaps execution, one instruction a clock
// RQ24 - interrupt return takes four cycles, pops, sets bit 7
// RQ25 - status word resets to zero
module cpd_core
   import cpd_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // decoder command
   input wire logic cmd_valid,
   input wire cpd_cmd_t cmd,
   input wire cpd_alu_op_t alu_op,
   input wire logic [4:0] rd,
   input wire logic [4:0] rr,
   input wire logic [7:0] imm,
   input wire logic use_imm,
   input wire logic [2:0] bit_sel,
   input wire logic [1:0] ptr_sel,
   input wire cpd_ptr_mode_t ptr_mode,
   input wire logic [5:0] disp,
   input wire logic [7:0] load_data,
   output logic busy,
   // I/O register port
   input wire logic [5:0] io_addr,
   input wire logic io_we,
   input wire logic io_re,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // data space window on the register file
   input wire logic [4:0] ds_addr,
   input wire logic ds_we,
   input wire logic ds_re,
   input wire logic [7:0] ds_wdata,
   output logic [7:0] ds_rdata,
   // memory side results
   output logic [15:0] ptr_addr,
   output logic [7:0] store_data,
   output logic [SPW-1:0] stack_ptr,
   output logic [7:0] status_word,
   // interrupt gating
   input wire logic irq_pending,
   output logic irq_allowed
);
   cpd_alu_if alu_bus ();

   logic [7:0] sw_r;
   logic [7:0] sw_nxt;
   logic [SPW-1:0] sp_r;
   logic [SPW-1:0] sp_nxt;
   cpd_state_t st_r;
   cpd_state_t st_nxt;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic [7:0] io_rdata_r;
   logic [7:0] io_rdata_nxt;
   logic [7:0] ds_rdata_r;
   logic [7:0] ds_rdata_nxt;
   logic [15:0] ptr_addr_r;
   logic [15:0] ptr_addr_nxt;
   logic [7:0] store_r;
   logic [7:0] store_nxt;

   logic [4:0] ra;
   logic [7:0] ra_d;
   logic [7:0] rb_d;
   logic [3:0] rp;
   logic [15:0] rp_d;
   logic we8;
   logic [4:0] wa;
   logic [7:0] wd8;
   logic we16;
   logic [3:0] wp;
   logic [15:0] wd16;
   logic take;

   // register file and core registers are clocked straight from mclk, no divider [RQ22]
   cpd_regfile #(
      .N(NREG)
   ) u_rf (
      .mclk(mclk),
      .arst_n(arst_n),
      .ra(ra),
      .rb(rr),
      .ra_d(ra_d),
      .rb_d(rb_d),
      .rp(rp),
      .rp_d(rp_d),
      .we8(we8),
      .wa(wa),
      .wd8(wd8),
      .we16(we16),
      .wp(wp),
      .wd16(wd16)
   );

   cpd_alu u_alu (
      .bus(alu_bus)
   );

   assign take = cmd_valid && st_r == ST_IDLE;
   assign busy = st_r != ST_IDLE;
   assign ra = (cmd_valid || !ds_re) ? rd : ds_addr;

   // operand steering for the arithmetic unit
   always_comb
   begin
      alu_bus.a = ra_d;
      alu_bus.b = use_imm ? imm : rb_d; // [RQ1]
      alu_bus.cin = sw_r[SW_C];
      alu_bus.op = alu_op;
   end

   // pointer pair select and register file writes
   always_comb
   begin
      logic [15:0] p;
      p = rp_d;
      rp = (cmd == CMD_MOVW) ? rr[4:1] : PAIR_BASE + {2'b00, ptr_sel};
      we8 = 1'b0;
      wa = rd;
      wd8 = alu_bus.res;
      we16 = 1'b0;
      wp = rp;
      wd16 = rp_d;
      ptr_addr_nxt = ptr_addr_r;
      if (take)
      begin
         case (cmd)
            CMD_ALU:
               we8 = 1'b1; // [RQ1] [RQ2]
            CMD_TLOAD:
            begin
               we8 = 1'b1;
               wd8 = ra_d;
               wd8[bit_sel] = sw_r[SW_T]; // [RQ7]
            end
            CMD_LOAD, CMD_POP:
            begin
               we8 = 1'b1;
               wd8 = load_data;
            end
            CMD_PTR:
            begin
               case (ptr_mode) // [RQ17]
                  PTR_POSTINC:
                  begin
                     ptr_addr_nxt = p;
                     we16 = 1'b1;
                     wd16 = p + 16'h0001;
                  end
                  PTR_PREDEC:
                  begin
                     ptr_addr_nxt = p - 16'h0001;
                     we16 = 1'b1;
                     wd16 = p - 16'h0001;
                  end
                  default:
                     ptr_addr_nxt = p + {10'h000, disp};
               endcase
            end
            CMD_MOVW:
            begin
               we16 = 1'b1;
               wp = rd[4:1];
            end
            default:
               we8 = 1'b0;
         endcase
      end
      else if (ds_we && !cmd_valid)
      begin
         we8 = 1'b1; // [RQ15]
         wa = ds_addr;
         wd8 = ds_wdata;
      end
   end

   // status word, stack pointer and return sequencer
   always_comb
   begin
      sw_nxt = sw_r;
      sp_nxt = sp_r;
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      store_nxt = store_r;
      if (io_we)
      begin
         case (io_addr)
            IO_SP_LO: sp_nxt[7:0] = io_wdata; // [RQ20]
            IO_SP_HI: sp_nxt[SPW-1:8] = io_wdata[SPW-9:0];
            IO_SW: sw_nxt = io_wdata;
            default: sw_nxt = sw_nxt;
         endcase
      end
      case (st_r)
         ST_IRET:
         begin
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == IRET_LAST)
            begin
               st_nxt = ST_IDLE;
               sp_nxt = sp_r + SPW'(2); // [RQ24]
               sw_nxt[SW_I] = 1'b1; // [RQ6] [RQ24]
            end
         end
         default:
         begin
            if (take)
            begin
               case (cmd)
                  CMD_ALU:
                     // other bits keep their value [RQ3] [RQ8] [RQ10]
                     sw_nxt = (sw_r & ~alu_bus.mask) |
                        (alu_bus.flags & alu_bus.mask); // [RQ11] [RQ12] [RQ13]
                  CMD_TSAVE: sw_nxt[SW_T] = ra_d[bit_sel]; // [RQ7]
                  CMD_STORE: store_nxt = ra_d;
                  CMD_PUSH: sp_nxt = sp_r - SPW'(1); // [RQ18]
                  CMD_POP: sp_nxt = sp_r + SPW'(1); // [RQ18]
                  CMD_CALL: sp_nxt = sp_r - SPW'(2); // [RQ19]
                  CMD_RTN: sp_nxt = sp_r + SPW'(2); // [RQ19]
                  CMD_IRQ:
                  begin
                     // rest of the word is left for software [RQ4]
                     sp_nxt = sp_r - SPW'(2); // [RQ19]
                     sw_nxt[SW_I] = 1'b0; // [RQ6]
                  end
                  CMD_IRET:
                  begin
                     st_nxt = ST_IRET; // [RQ24]
                     cnt_nxt = 2'h0;
                  end
                  CMD_SEI: sw_nxt[SW_I] = 1'b1; // [RQ6]
                  CMD_CLI: sw_nxt[SW_I] = 1'b0; // [RQ6]
                  default: st_nxt = ST_IDLE;
               endcase
            end
         end
      endcase
   end

   // registered read data
   always_comb
   begin
      io_rdata_nxt = io_rdata_r;
      ds_rdata_nxt = ds_rdata_r;
      if (io_re)
      begin
         case (io_addr)
            IO_SP_LO: io_rdata_nxt = sp_r[7:0];
            IO_SP_HI: io_rdata_nxt = {5'h00, sp_r[SPW-1:8]}; // [RQ20]
            IO_SW: io_rdata_nxt = sw_r;
            default: io_rdata_nxt = 8'h00;
         endcase
      end
      if (ds_re && !cmd_valid)
         ds_rdata_nxt = ra_d; // [RQ15]
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sw_r <= SW_RST; // [RQ25]
         sp_r <= {SP_HI_RST[SPW-9:0], SP_LO_RST}; // [RQ20]
         st_r <= ST_IDLE;
         cnt_r <= 2'h0;
         io_rdata_r <= 8'h00;
         ds_rdata_r <= 8'h00;
         ptr_addr_r <= 16'h0000;
         store_r <= 8'h00;
      end
      else
      begin
         sw_r <= sw_nxt;
         sp_r <= sp_nxt;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         io_rdata_r <= io_rdata_nxt;
         ds_rdata_r <= ds_rdata_nxt;
         ptr_addr_r <= ptr_addr_nxt;
         store_r <= store_nxt;
      end
   end

   // a command is accepted every clock while idle [RQ23]
   assign irq_allowed = irq_pending && sw_r[SW_I] && !busy; // [RQ5]
   assign io_rdata = io_rdata_r;
   assign ds_rdata = ds_rdata_r;
   assign ptr_addr = ptr_addr_r;
   assign store_data = store_r;
   assign stack_ptr = sp_r;
   assign status_word = sw_r;
endmodule : cpd_core

// ### tb/cpd_mem_model.sv
// data memory model beside the core, returning stack bytes for pops
// assumes the bench hands it the stack pointer and the pop and load strobe
module cpd_mem_model
   import cpd_pkg::*;
(
   // clock
   input wire logic mclk,
   // read request
   input wire logic rd_en,
   input wire logic [SPW-1:0] sp,
   // read data
   output logic [7:0] load_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last = 8'h00;
   // pop or load reads the byte just above the pointer; else a toggling pattern
   always_comb
   begin
      if (rd_en)
         load_data = 8'(sp + 11'h001) ^ 8'hC3;
      else
         load_data = ~last;
   end
   always @(posedge mclk)
      last <= load_data;
endmodule : cpd_mem_model

// ### tb/cpd_core_asserts.sv
// port checker of the core datapath slice
// assumes bound into cpd_core, one clock domain
module cpd_core_asserts
   import cpd_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // watched ports
   input wire logic cmd_valid,
   input wire cpd_cmd_t cmd,
   input wire logic io_we,
   input wire logic busy,
   input wire logic [SPW-1:0] stack_ptr,
   input wire logic [7:0] status_word,
   input wire logic irq_pending,
   input wire logic irq_allowed
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   logic go;
   assign go = cmd_valid && !busy && !io_we;
   sequence take(cpd_cmd_t c);
      go && cmd == c;
   endsequence
   sequence iret_wait;
      busy [*3] ##1 !busy;
   endsequence
   AST_IRET_BUSY: assert property (take(CMD_IRET) |=> iret_wait)
      else $error("busy window of interrupt return wrong");
   AST_IRET_SP: assert property (take(CMD_IRET) |-> ##4
      stack_ptr == $past(stack_ptr, 4) + 11'h002 && status_word[SW_I])
      else $error("interrupt return did not pop or enable");
   AST_IRET_KEEP: assert property (take(CMD_IRET) |-> ##4
      status_word[6:0] == $past(status_word[6:0], 4))
      else $error("interrupt return changed status flags");
   AST_IRQ_GATE: assert property (irq_allowed ==
      (irq_pending && status_word[SW_I] && !busy))
      else $error("interrupt gating wrong");
   AST_PUSH: assert property (take(CMD_PUSH) |=>
      stack_ptr == $past(stack_ptr) - 11'h001)
      else $error("push did not step pointer down by one");
   AST_POP: assert property (take(CMD_POP) |=>
      stack_ptr == $past(stack_ptr) + 11'h001)
      else $error("pop did not step pointer up by one");
   AST_CALL: assert property (take(CMD_CALL) or take(CMD_IRQ) |=>
      stack_ptr == $past(stack_ptr) - 11'h002)
      else $error("call or interrupt did not step down by two");
   AST_RTN: assert property (take(CMD_RTN) |=>
      stack_ptr == $past(stack_ptr) + 11'h002)
      else $error("return did not step up by two");
   AST_CLR_I: assert property (take(CMD_IRQ) or take(CMD_CLI) |=>
      !status_word[SW_I])
      else $error("enable bit not cleared");
   AST_SET_I: assert property (take(CMD_SEI) |=> status_word[SW_I])
      else $error("enable bit not set");
   AST_SIGN: assert property (take(CMD_ALU) |=>
      status_word[SW_S] == (status_word[SW_N] ^ status_word[SW_V]))
      else $error("sign flag not negative xor overflow");
endmodule : cpd_core_asserts
bind cpd_core cpd_core_asserts u_chk (.mclk(mclk), .arst_n(arst_n),
   .cmd_valid(cmd_valid), .cmd(cmd), .io_we(io_we), .busy(busy),
   .stack_ptr(stack_ptr), .status_word(status_word),
   .irq_pending(irq_pending), .irq_allowed(irq_allowed));

// ### tb/cpd_core_tb.sv
// self-checking bench of the core datapath slice
// assumes package, interface, design, model and checker compiled first
module cpd_core_tb
   import cpd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [2:0] sel;
      logic [15:0] exp;
   } cpd_note_t;
   logic mclk = 1'b0, arst_n = 1'b0, irq_pending = 1'b0, use_imm = 1'b0;
   logic cmd_valid = 1'b0, io_we = 1'b0, io_re = 1'b0;
   logic ds_we = 1'b0, ds_re = 1'b0;
   cpd_cmd_t cmd = CMD_NOP;
   cpd_alu_op_t alu_op = ALU_ADD;
   cpd_ptr_mode_t ptr_mode = PTR_DISP;
   logic [4:0] rd = 5'h00, rr = 5'h00, ds_addr = 5'h00;
   logic [7:0] imm = 8'h00, io_wdata = 8'h00, ds_wdata = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [1:0] ptr_sel = 2'h0;
   logic [5:0] disp = 6'h3F, io_addr = 6'h00;
   logic [7:0] load_data, io_rdata, ds_rdata, store_data, status_word;
   logic [15:0] ptr_addr, p;
   logic [SPW-1:0] stack_ptr, sp;
   logic busy, irq_allowed;
   logic [7:0] rf [32];
   logic [7:0] sw, a, b;
   cpd_note_t q[$];
   cpd_note_t n;
   int mismatches = 0;
   int n_compared = 0;
   int seed = 44;
   cpd_cmd_t stk [8] = '{CMD_PUSH, CMD_POP, CMD_CALL, CMD_RTN,
      CMD_SEI, CMD_IRQ, CMD_SEI, CMD_CLI};
   cpd_alu_op_t ops [6] = '{ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_EOR,
      ALU_COM};
   cpd_ptr_mode_t pm [3] = '{PTR_POSTINC, PTR_PREDEC, PTR_DISP};

   always #4 mclk = ~mclk;

   cpd_core dut (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
      .cmd(cmd), .alu_op(alu_op), .rd(rd), .rr(rr), .imm(imm),
      .use_imm(use_imm), .bit_sel(bit_sel), .ptr_sel(ptr_sel),
      .ptr_mode(ptr_mode), .disp(disp), .load_data(load_data),
      .busy(busy), .io_addr(io_addr), .io_we(io_we), .io_re(io_re),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .ds_addr(ds_addr),
      .ds_we(ds_we), .ds_re(ds_re), .ds_wdata(ds_wdata),
      .ds_rdata(ds_rdata), .ptr_addr(ptr_addr), .store_data(store_data),
      .stack_ptr(stack_ptr), .status_word(status_word),
      .irq_pending(irq_pending), .irq_allowed(irq_allowed));
   cpd_mem_model u_mem (.mclk(mclk),
      .rd_en(cmd_valid && (cmd == CMD_POP || cmd == CMD_LOAD)),
      .sp(stack_ptr), .load_data(load_data));

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   task automatic cmp(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic note(input logic [2:0] s, input logic [15:0] e);
      q.push_back('{s, e});
   endtask : note

   // strobes {cmd, io write, io read, ds write, ds read} for one edge
   task automatic drv(input logic [4:0] s);
      {cmd_valid, io_we, io_re, ds_we, ds_re} = s;
      @(negedge mclk);
   endtask : drv

   task automatic go(input cpd_cmd_t c);
      cmd = c;
      drv(5'h10);
   endtask : go

   task automatic io_wr(input logic [5:0] ad, input logic [7:0] d);
      io_addr = ad;
      io_wdata = d;
      drv(5'h08);
   endtask : io_wr

   task automatic io_rd(input logic [5:0] ad, input logic [7:0] e);
      io_addr = ad;
      note(3'h2, 16'(e));
      drv(5'h04);
   endtask : io_rd

   task automatic ds_wr(input logic [4:0] ad, input logic [7:0] d);
      ds_addr = ad;
      ds_wdata = d;
      rf[ad] = d;
      drv(5'h02);
   endtask : ds_wr

   task automatic ds_rd(input logic [4:0] ad);
      ds_addr = ad;
      note(3'h3, 16'(rf[ad]));
      drv(5'h01);
   endtask : ds_rd

   task automatic alu_ref(input cpd_alu_op_t o);
      logic [8:0] s;
      logic [4:0] h;
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      s = {1'b0, a} + {1'b0, b};
      sw[SW_V] = 1'b0;
      case (o)
         ALU_ADD: sw[SW_V] = (a[7] == b[7]) && (s[7] != a[7]);
         ALU_SUB:
         begin
            h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
            s = {1'b0, a} - {1'b0, b};
            sw[SW_V] = (a[7] != b[7]) && (s[7] != a[7]);
         end
         ALU_AND: s = {1'b0, a & b};
         ALU_OR: s = {1'b0, a | b};
         ALU_COM:
         begin
            s = {1'b0, ~a};
            sw[SW_C] = 1'b1;
         end
         default: s = {1'b0, a ^ b};
      endcase
      if (o == ALU_ADD || o == ALU_SUB)
      begin
         sw[SW_C] = s[8];
         sw[SW_H] = h[4];
      end
      sw[SW_N] = s[7];
      sw[SW_Z] = s[7:0] == 8'h00;
      sw[SW_S] = sw[SW_N] ^ sw[SW_V];
      rf[rd] = s[7:0];
   endtask : alu_ref

   // results are looked at just after the edge that takes the request
   always @(posedge mclk)
   begin
      #1;
      while (q.size() > 0)
      begin
         n = q.pop_front();
         case (n.sel)
            3'h0: cmp("stack_ptr", n.exp, 16'(stack_ptr));
            3'h1: cmp("status_word", n.exp, 16'(status_word));
            3'h2: cmp("io_rdata", n.exp, 16'(io_rdata));
            3'h3: cmp("ds_rdata", n.exp, 16'(ds_rdata));
            3'h4: cmp("ptr_addr", n.exp, ptr_addr);
            3'h5: cmp("store_data", n.exp, 16'(store_data));
            default: cmp("busy_irq", n.exp, 16'({busy, irq_allowed}));
         endcase
      end
   end

   initial
   begin
      #(8 * 5000);
      mismatches++;
      summarize();
   end

   initial
   begin
      foreach (rf[i])
         rf[i] = 8'h00;
      sw = 8'h00;
      repeat (8) @(negedge mclk);
      arst_n = 1'b1;
      io_rd(IO_SP_LO, SP_LO_RST);
      io_rd(IO_SP_HI, SP_HI_RST);
      io_rd(IO_SW, SW_RST);
      io_rd(6'h10, 8'h00);
      io_wr(IO_SP_LO, 8'h55);
      io_wr(IO_SP_HI, 8'hFD);
      io_rd(IO_SP_HI, 8'h05);
      sp = 11'h555;
      irq_pending = 1'b1;
      rd = 5'h04;
      foreach (stk[i])
      begin
         case (stk[i])
            CMD_PUSH: sp = sp - 11'h001;
            CMD_POP:
            begin
               sp = sp + 11'h001;
               rf[4] = 8'(sp) ^ 8'hC3;
            end
            CMD_RTN: sp = sp + 11'h002;
            CMD_SEI: sw[SW_I] = 1'b1;
            CMD_CLI: sw[SW_I] = 1'b0;
            default:
            begin
               sp = sp - 11'h002;
               sw[SW_I] = 1'b0;
            end
         endcase
         note(3'h0, 16'(sp));
         note(3'h6, {15'h0000, sw[SW_I]});
         go(stk[i]);
      end
      ds_rd(5'h04);
      rd = 5'h09;
      rf[9] = 8'(sp + 11'h001) ^ 8'hC3;
      go(CMD_LOAD);
      ds_rd(5'h09);
      // pushes offered during the return window must be refused
      cmd = CMD_IRET;
      for (int i = 0; i < IRET_CYC; i++)
      begin
         if (i == IRET_CYC - 1)
         begin
            sp = sp + 11'h002;
            sw[SW_I] = 1'b1;
            note(3'h0, 16'(sp));
            note(3'h1, 16'(sw));
         end
         note(3'h6, (i == IRET_CYC - 1) ? 16'h0001 : 16'h0002);
         drv(5'h10);
         cmd = CMD_PUSH;
      end
      drv(5'h00);
      for (int i = 0; i < 15; i++)
      begin
         a = 8'($random(seed));
         b = 8'($random(seed));
         rd = 5'($random(seed));
         rr = rd ^ 5'h01;
         use_imm = 1'($random(seed));
         imm = b;
         alu_op = ops[i % 6];
         ds_wr(rd, a);
         ds_wr(rr, b);
         alu_ref(alu_op);
         note(3'h1, 16'(sw));
         go(CMD_ALU);
         ds_rd(rd);
      end
      ds_wr(5'h07, 8'hA5);
      ds_wr(5'h08, 8'h5A);
      for (int i = 0; i < 8; i++)
      begin
         bit_sel = 3'(i);
         rd = 5'h07;
         sw[SW_T] = rf[7][i];
         note(3'h1, 16'(sw));
         go(CMD_TSAVE);
         rd = 5'h08;
         rf[8][i] = sw[SW_T];
         go(CMD_TLOAD);
      end
      ds_rd(5'h08);
      for (int k = 0; k < 3; k++)
      begin
         p = 16'h12FF;
         ds_wr(5'(26 + 2 * k), 8'hFF);
         ds_wr(5'(27 + 2 * k), 8'h12);
         ptr_sel = 2'(k);
         foreach (pm[j])
         begin
            ptr_mode = pm[j];
            p = (pm[j] == PTR_PREDEC) ? p - 16'h0001 : p;
            note(3'h4, (pm[j] == PTR_DISP) ? p + 16'h003F : p);
            go(CMD_PTR);
            p = (pm[j] == PTR_POSTINC) ? p + 16'h0001 : p;
         end
         {rf[27 + 2 * k], rf[26 + 2 * k]} = p;
         ds_rd(5'(26 + 2 * k));
         ds_rd(5'(27 + 2 * k));
      end
      rd = 5'h1F;
      note(3'h5, 16'(rf[31]));
      go(CMD_STORE);
      rd = 5'h00;
      rr = 5'h1E;
      rf[0] = rf[30];
      rf[1] = rf[31];
      go(CMD_MOVW);
      ds_rd(5'h00);
      ds_rd(5'h01);
      drv(5'h00);
      summarize();
   end
endmodule : cpd_core_tb
